//--- shared/ams_pkg.sv
// Register map, field layout, mode codes and timing for the mode sequencer
package ams_pkg;
	localparam logic [7:0] MODE_OFS    = 8'h00;
	localparam logic [7:0] CONFIG_OFS  = 8'h04;
	localparam logic [7:0] STATUS_OFS  = 8'h08;
	localparam logic [7:0] DATA_OFS    = 8'h0c;
	localparam logic [7:0] OFFSET_BASE = 8'h10;
	localparam logic [7:0] FSCALE_BASE = 8'h1c;
	localparam logic [7:0] IRQ_ST_OFS  = 8'h28;
	localparam logic [7:0] IRQ_MSK_OFS = 8'h2c;

	// Mode register: operating_mode_field [15:13], update_rate_select [3:0]
	localparam int          OP_LSB     = 13;
	localparam int          RATE_LSB   = 0;
	localparam logic [15:0] MODE_RST   = 16'h400a;
	localparam logic [15:0] MODE_WMASK = 16'he00f;

	// Config register fields
	localparam int          CHAN_LSB    = 0;
	localparam int          EXC_BIT     = 4;
	localparam int          CLOCK_OUTPUT_DRIVER_BIT  = 5;
	localparam int          REFINT_BIT  = 7;
	localparam int          GAIN_LSB    = 8;
	localparam int          BURNOUT_BIT = 13;
	localparam int          BIAS_BIT    = 14;
	localparam logic [15:0] CFG_RST     = 16'h0000;
	localparam logic [15:0] CFG_WMASK   = 16'h67b3;

	localparam logic [2:0] OP_CONT   = 3'h0;
	localparam logic [2:0] OP_SINGLE = 3'h1;
	localparam logic [2:0] OP_IDLE   = 3'h2;
	localparam logic [2:0] OP_PDOWN  = 3'h3;
	localparam logic [2:0] OP_ZCAL   = 3'h4;
	localparam logic [2:0] OP_FCAL   = 3'h5;

	localparam logic [2:0] GAIN_1   = 3'h0;
	localparam logic [2:0] GAIN_128 = 3'h7;

	// Status register bits
	localparam int ST_RDYN_BIT  = 0;
	localparam int ST_PDOWN_BIT = 1;
	localparam int ST_BUSY_BIT  = 2;
	localparam int ST_OP_LSB    = 4;

	// Interrupt status and mask bits
	localparam int IRQ_W       = 3;
	localparam int IRQ_CONV    = 0;
	localparam int IRQ_CAL     = 1;
	localparam int IRQ_REFUSED = 2;

	// Conversion cycles per operation
	localparam logic [2:0] SINGLE_CYCLES  = 3'h2;
	localparam logic [2:0] ZCAL_CYCLES    = 3'h2;
	localparam logic [2:0] FCAL_G1_CYCLES = 3'h2;
	localparam logic [2:0] FCAL_CYCLES    = 3'h4;

	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_US     = 1000;
	localparam int CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;

	// One conversion cycle in microseconds per rate code; code 0 runs as code 1
	function automatic int unsigned rate_period_us(input logic [3:0] code);
		unique case (code)
			4'h0, 4'h1: return 2000;
			4'h2: return 4000;
			4'h3: return 8000;
			4'h4: return 16000;
			4'h5: return 20000;
			4'h6: return 24038;
			4'h7: return 30030;
			4'h8: return 51020;
			4'h9, 4'ha: return 60241;
			4'hb: return 80000;
			4'hc: return 100000;
			4'hd: return 120048;
			4'he: return 160000;
			default: return 239808;
		endcase
	endfunction
endpackage

//--- rtl/ams_mode_sequencer.sv
// Operating-mode sequencer: single conversion, idle, power-down, internal calibrations
// Summary of operation
// RL1: Single mode powers up, runs one conversion lasting two conversion cycles.
// RL2: Conversion end stores result, drops ready flag, returns to power-down.
// RL3: Result and low ready flag hold until data read or next conversion.
// RL4: Idle holds filter and modulator in reset, modulator clocks kept running.
// RL5: Power-down switches off excitation, burnout, bias and clock output driver.
// RL6: Zero-scale calibration shorts enabled channel, lasts two conversion cycles.
// RL7: Internal calibration raises ready flag at start, lowers it when finished.
// RL8: After any internal calibration the sequencer enters idle.
// RL9: Zero-scale calibration stores offset coefficient for selected channel.
// RL10: Full-scale calibration routes full-scale voltage to selected input.
// RL11: Gain 1 with internal reference loads factory full-scale value instead.
// RL12: Gain 1 with external reference full-scale calibration takes two cycles.
// RL13: Host must not request internal full-scale calibration at gain 128.
// RL14: Other gains need four conversion cycles for full-scale calibration.
// RL15: Full-scale calibration stores coefficient for selected channel.
// RL16: Completed conversion is signalled by driving the ready flag low.
// RL17: Four-bit update-rate field in mode register sets conversion cycle length.
// RL18: Gain 128 request leaves coefficient, pulses ready high briefly, enters idle.
module ams_mode_sequencer #(
	parameter int          CONV_SCALE = ams_pkg::CYC_PER_US,
	parameter int          NUM_CH     = 3,
	parameter int          COEF_W     = 24,
	parameter logic [23:0] FACTORY_FS = 24'h500000
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [COEF_W-1:0] sampleData,
	output logic                   readyN,
	output logic                   filterReset,
	output logic                   modulatorClkEn,
	output logic                   powerDown,
	output logic                   excitationEn,
	output logic                   burnoutEn,
	output logic                   biasEn,
	output logic                   clockOutputDriverEn,
	output logic                   inputShort,
	output logic                   fullScaleRoute,
	output logic                   irq
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_PDOWN, ST_CONV, ST_ZCAL, ST_FCAL, ST_FINISH
	} ams_state_e;

	ams_state_e        stateReg, stateNext;
	logic [15:0]       modeReg, modeNext;
	logic [15:0]       cfgReg, cfgNext;
	logic [COEF_W-1:0] dataReg, dataNext;
	logic [COEF_W-1:0] offsetReg [NUM_CH];
	logic [COEF_W-1:0] offsetNext [NUM_CH];
	logic [COEF_W-1:0] fscaleReg [NUM_CH];
	logic [COEF_W-1:0] fscaleNext [NUM_CH];
	logic [31:0]       periodCntReg, periodCntNext;
	logic [2:0]        cycCntReg, cycCntNext;
	logic [2:0]        targetReg, targetNext;
	logic [1:0]        calChanReg, calChanNext;
	logic              refusedReg, refusedNext;
	logic [ams_pkg::IRQ_W-1:0] irqStatReg, irqStatNext;
	logic [ams_pkg::IRQ_W-1:0] irqMaskReg, irqMaskNext;
	logic [31:0]       prdataReg, prdataNext;
	logic              preadyReg, preadyNext;
	logic              pslverrReg, pslverrNext;
	logic              readyNReg, readyNNext;
	logic [8:0]        pinsReg, pinsNext;
	logic              irqReg, irqNext;

	// Conversion cycle length in clocks, less one, for a rate code
	function automatic logic [31:0] cycles_less_one(input logic [3:0] rate);
		logic [31:0] len;
		len = 32'(ams_pkg::rate_period_us(rate) * CONV_SCALE);
		return len - 32'h1;
	endfunction

	// Register index decode; coefficient slots follow their base word by word
	function automatic logic mapped(input logic [7:0] a);
		logic ok;
		ok = (a[1:0] == 2'h0) && (a < ams_pkg::IRQ_MSK_OFS + 8'h4);
		return ok;
	endfunction

	always_comb begin
		logic            accW;
		logic            accR;
		logic [7:0]      a;
		logic [2:0]      op;
		logic [2:0]      gain;
		logic [1:0]      chan;
		logic [ams_pkg::IRQ_W-1:0] evt;
		logic [ams_pkg::IRQ_W-1:0] clr;
		logic            active;
		logic            pd;
		accW = psel & penable & preadyReg & pwrite;
		accR = psel & penable & preadyReg & ~pwrite;
		a = paddr;
		op = pwdata[ams_pkg::OP_LSB +: 3];
		gain = cfgReg[ams_pkg::GAIN_LSB +: 3];
		chan = cfgReg[ams_pkg::CHAN_LSB +: 2];
		evt = '0;
		clr = '0;
		active = 1'b0;
		pd = 1'b0;
		stateNext = stateReg;
		modeNext = modeReg;
		cfgNext = cfgReg;
		dataNext = dataReg;
		offsetNext = offsetReg;
		fscaleNext = fscaleReg;
		periodCntNext = periodCntReg;
		cycCntNext = cycCntReg;
		targetNext = targetReg;
		calChanNext = calChanReg;
		refusedNext = refusedReg;
		irqMaskNext = irqMaskReg;
		readyNNext = readyNReg;

		// APB: one wait state, answer registered
		preadyNext = psel & penable & ~preadyReg;
		pslverrNext = psel & penable & ~preadyReg & ~mapped(a);
		prdataNext = prdataReg;
		if (psel & penable & ~preadyReg) begin
			prdataNext = 32'h0;
			for (int i = 0; i < NUM_CH; i++) begin
				if (a == ams_pkg::OFFSET_BASE + 8'(4 * i)) begin
					prdataNext = 32'(offsetReg[i]);
				end
				if (a == ams_pkg::FSCALE_BASE + 8'(4 * i)) begin
					prdataNext = 32'(fscaleReg[i]);
				end
			end
			unique case (a)
				ams_pkg::MODE_OFS: prdataNext = 32'(modeReg);
				ams_pkg::CONFIG_OFS: prdataNext = 32'(cfgReg);
				ams_pkg::STATUS_OFS: begin
					prdataNext[ams_pkg::ST_RDYN_BIT] = readyNReg;
					prdataNext[ams_pkg::ST_PDOWN_BIT] = (stateReg == ST_PDOWN);
					prdataNext[ams_pkg::ST_BUSY_BIT] =
						(stateReg != ST_IDLE) && (stateReg != ST_PDOWN);
					prdataNext[ams_pkg::ST_OP_LSB +: 3] = modeReg[ams_pkg::OP_LSB +: 3];
				end
				ams_pkg::DATA_OFS: prdataNext = 32'(dataReg);
				ams_pkg::IRQ_ST_OFS: prdataNext = 32'(irqStatReg);
				ams_pkg::IRQ_MSK_OFS: prdataNext = 32'(irqMaskReg);
				default: ;
			endcase
		end

		// Running operation: count conversion cycles
		if (stateReg == ST_CONV || stateReg == ST_ZCAL || stateReg == ST_FCAL) begin
			if (periodCntReg != 32'h0) begin
				periodCntNext = periodCntReg - 32'h1;
			end else begin
				periodCntNext = cycles_less_one(modeReg[ams_pkg::RATE_LSB +: 4]); // RL17
				cycCntNext = cycCntReg + 3'h1;
				if (cycCntNext == targetReg) begin
					readyNNext = 1'b0; // RL16 RL7
					if (stateReg == ST_CONV) begin
						dataNext = sampleData; // RL2
						stateNext = ST_PDOWN; // RL2
						evt[ams_pkg::IRQ_CONV] = 1'b1;
					end else begin
						if (calChanReg < 2'(NUM_CH)) begin
							if (stateReg == ST_ZCAL) begin
								offsetNext[calChanReg] = sampleData; // RL9
							end else begin
								fscaleNext[calChanReg] = sampleData; // RL15
							end
						end
						stateNext = ST_IDLE; // RL8
						modeNext[ams_pkg::OP_LSB +: 3] = ams_pkg::OP_IDLE;
						evt[ams_pkg::IRQ_CAL] = 1'b1;
					end
				end
			end
		end
		if (stateReg == ST_FINISH) begin
			readyNNext = 1'b0; // RL7 RL18
			stateNext = ST_IDLE; // RL8 RL18
			modeNext[ams_pkg::OP_LSB +: 3] = ams_pkg::OP_IDLE;
			evt[refusedReg ? ams_pkg::IRQ_REFUSED : ams_pkg::IRQ_CAL] = 1'b1;
		end

		// Reading the result releases the ready flag
		if (accR && a == ams_pkg::DATA_OFS && stateReg != ST_ZCAL &&
				stateReg != ST_FCAL && stateReg != ST_FINISH) begin
			readyNNext = 1'b1; // RL3
		end

		// Register writes; a mode write supersedes any running operation
		if (accW) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (a == ams_pkg::OFFSET_BASE + 8'(4 * i)) begin
					offsetNext[i] = pwdata[COEF_W-1:0];
				end
				if (a == ams_pkg::FSCALE_BASE + 8'(4 * i)) begin
					fscaleNext[i] = pwdata[COEF_W-1:0];
				end
			end
			if (a == ams_pkg::CONFIG_OFS) begin
				cfgNext = pwdata[15:0] & ams_pkg::CFG_WMASK;
			end
			if (a == ams_pkg::IRQ_MSK_OFS) begin
				irqMaskNext = pwdata[ams_pkg::IRQ_W-1:0];
			end
			if (a == ams_pkg::IRQ_ST_OFS) begin
				clr = pwdata[ams_pkg::IRQ_W-1:0];
			end
			if (a == ams_pkg::MODE_OFS) begin
				modeNext = pwdata[15:0] & ams_pkg::MODE_WMASK;
				periodCntNext = cycles_less_one(pwdata[ams_pkg::RATE_LSB +: 4]); // RL17
				cycCntNext = 3'h0;
				calChanNext = chan;
				refusedNext = 1'b0;
				unique case (op)
					ams_pkg::OP_SINGLE: begin
						stateNext = ST_CONV; // RL1
						targetNext = ams_pkg::SINGLE_CYCLES; // RL1
						readyNNext = 1'b1; // RL3
					end
					ams_pkg::OP_PDOWN: stateNext = ST_PDOWN; // RL5
					ams_pkg::OP_ZCAL: begin
						stateNext = ST_ZCAL; // RL6
						targetNext = ams_pkg::ZCAL_CYCLES; // RL6
						readyNNext = 1'b1; // RL7
					end
					ams_pkg::OP_FCAL: begin
						readyNNext = 1'b1; // RL7
						if (gain == ams_pkg::GAIN_128) begin
							stateNext = ST_FINISH; // RL18
							refusedNext = 1'b1; // RL18
						end else if (gain == ams_pkg::GAIN_1 &&
								cfgReg[ams_pkg::REFINT_BIT]) begin
							if (chan < 2'(NUM_CH)) begin
								fscaleNext[chan] = COEF_W'(FACTORY_FS); // RL11
							end
							stateNext = ST_FINISH; // RL11
						end else begin
							stateNext = ST_FCAL; // RL10
							targetNext = (gain == ams_pkg::GAIN_1) ?
								ams_pkg::FCAL_G1_CYCLES : ams_pkg::FCAL_CYCLES; // RL12 RL14
						end
					end
					default: stateNext = ST_IDLE; // RL4
				endcase
			end
		end

		// Set wins over a write-one clear
		irqStatNext = (irqStatReg & ~clr) | evt;
		irqNext = |(irqStatNext & irqMaskNext);

		// Analogue controls follow the next state
		active = stateNext == ST_CONV || stateNext == ST_ZCAL || stateNext == ST_FCAL;
		pd = stateNext == ST_PDOWN;
		pinsNext[0] = ~active; // RL4
		pinsNext[1] = ~pd; // RL4
		pinsNext[2] = pd; // RL1 RL5
		pinsNext[3] = cfgNext[ams_pkg::EXC_BIT] & ~pd; // RL5
		pinsNext[4] = cfgNext[ams_pkg::BURNOUT_BIT] & ~pd; // RL5
		pinsNext[5] = cfgNext[ams_pkg::BIAS_BIT] & ~pd; // RL5
		pinsNext[6] = cfgNext[ams_pkg::CLOCK_OUTPUT_DRIVER_BIT] & ~pd; // RL5
		pinsNext[7] = stateNext == ST_ZCAL; // RL6
		pinsNext[8] = stateNext == ST_FCAL; // RL10
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			stateReg <= ST_IDLE;
			modeReg <= ams_pkg::MODE_RST;
			cfgReg <= ams_pkg::CFG_RST;
			dataReg <= '0;
			offsetReg <= '{default: '0};
			fscaleReg <= '{default: '0};
			periodCntReg <= 32'h0;
			cycCntReg <= 3'h0;
			targetReg <= 3'h0;
			calChanReg <= 2'h0;
			refusedReg <= 1'b0;
			irqStatReg <= '0;
			irqMaskReg <= '0;
			prdataReg <= 32'h0;
			preadyReg <= 1'b0;
			pslverrReg <= 1'b0;
			readyNReg <= 1'b1;
			pinsReg <= 9'h003;
			irqReg <= 1'b0;
		end else begin
			stateReg <= stateNext;
			modeReg <= modeNext;
			cfgReg <= cfgNext;
			dataReg <= dataNext;
			offsetReg <= offsetNext;
			fscaleReg <= fscaleNext;
			periodCntReg <= periodCntNext;
			cycCntReg <= cycCntNext;
			targetReg <= targetNext;
			calChanReg <= calChanNext;
			refusedReg <= refusedNext;
			irqStatReg <= irqStatNext;
			irqMaskReg <= irqMaskNext;
			prdataReg <= prdataNext;
			preadyReg <= preadyNext;
			pslverrReg <= pslverrNext;
			readyNReg <= readyNNext;
			pinsReg <= pinsNext;
			irqReg <= irqNext;
		end
	end

	assign prdata = prdataReg;
	assign pready = preadyReg;
	assign pslverr = pslverrReg;
	assign readyN = readyNReg;
	assign filterReset = pinsReg[0];
	assign modulatorClkEn = pinsReg[1];
	assign powerDown = pinsReg[2];
	assign excitationEn = pinsReg[3];
	assign burnoutEn = pinsReg[4];
	assign biasEn = pinsReg[5];
	assign clockOutputDriverEn = pinsReg[6];
	assign inputShort = pinsReg[7];
	assign fullScaleRoute = pinsReg[8];
	assign irq = irqReg;
endmodule

//--- tb/ams_mode_sequencer_asserts.sv
// Port checks for the mode sequencer
module ams_mode_sequencer_asserts (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic readyN,
	input wire logic filterReset,
	input wire logic modulatorClkEn,
	input wire logic powerDown,
	input wire logic excitationEn,
	input wire logic burnoutEn,
	input wire logic biasEn,
	input wire logic clockOutputDriverEn,
	input wire logic inputShort,
	input wire logic fullScaleRoute
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered");
	AST_PREADY_PULSE: assert property (pready |-> $past(psel && penable) ##1 !pready)
		else $error("pready not a single pulse");
	AST_PDOWN_PINS: assert property (
		powerDown |-> !(excitationEn || burnoutEn || biasEn || clockOutputDriverEn))
		else $error("powered-down part drives a source");
	AST_CLK_RUN: assert property (modulatorClkEn == !powerDown)
		else $error("modulator clock state wrong");
	AST_PDOWN_RESET: assert property (powerDown |-> filterReset)
		else $error("filter live while powered down");
	AST_RDY_HOLD: assert property (
		!readyN && !(psel && penable && pready) |=> !readyN)
		else $error("ready flag rose without an access");
	AST_FALL_PARK: assert property (
		$fell(readyN) |-> filterReset && !inputShort && !fullScaleRoute)
		else $error("finish did not park the converter");
	AST_SHORT_RDY: assert property (
		$rose(inputShort) |-> (inputShort && readyN && !filterReset)[*8])
		else $error("zero calibration not held busy");
	AST_ROUTE_RDY: assert property (
		fullScaleRoute |-> readyN && !inputShort && !powerDown)
		else $error("full-scale route outside calibration");
	C_SINGLE: cover property ($fell(readyN) && powerDown);
	C_ZERO: cover property ($rose(inputShort));
	C_FULL: cover property ($rose(fullScaleRoute));
endmodule
bind ams_mode_sequencer ams_mode_sequencer_asserts ams_mode_sequencer_asserts_i (
	.ref_clk, .rst_b, .psel, .penable, .pready, .readyN, .filterReset, .modulatorClkEn,
	.powerDown, .excitationEn, .burnoutEn, .biasEn, .clockOutputDriverEn, .inputShort,
	.fullScaleRoute);

//--- tb/ams_modulator_model.sv
// Modulator model feeding results to the sequencer
module ams_modulator_model (
	input wire logic        ref_clk,
	input wire logic        filterReset,
	input wire logic        modulatorClkEn,
	input wire logic [23:0] level,
	output logic     [23:0] sampleData
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [23:0] churn = 24'h0;
	// Unclocked or in reset: output is churn, which negates zero and so stays zero, so a stale capture shows
	always_ff @(posedge ref_clk) churn <= ~churn + 24'h1;
	assign sampleData = (modulatorClkEn && !filterReset) ? level : churn;
endmodule

//--- tb/ams_mode_sequencer_tb_top.sv
// Self-checking bench for the mode sequencer
module ams_mode_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [23:0] FACT = 24'h3c3c3c;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic [23:0] sampleData;
	logic [23:0] level = 24'h0;
	logic        pready, pslverr, readyN, filterReset, modulatorClkEn, powerDown, irq;
	logic        excitationEn, burnoutEn, biasEn, clockOutputDriverEn, inputShort;
	logic        fullScaleRoute, er, shortSeen, routeSeen, rdySeen, pdSeen;
	int          badCount = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          cycles;

	ams_mode_sequencer #(.CONV_SCALE(1), .FACTORY_FS(FACT)) ams_mode_sequencer_i (
		.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .sampleData, .readyN, .filterReset, .modulatorClkEn, .powerDown,
		.excitationEn, .burnoutEn, .biasEn, .clockOutputDriverEn, .inputShort,
		.fullScaleRoute, .irq);
	ams_modulator_model ams_modulator_model_i (
		.ref_clk, .filterReset, .modulatorClkEn, .level, .sampleData);

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic results();
		if (badCount == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 50000) begin
			badCount++;
			results();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			badCount++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] pins();
		return {28'h0, excitationEn, burnoutEn, biasEn, clockOutputDriverEn};
	endfunction

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Start an operation and count clocks until the ready flag drops
	task automatic runOp(input logic [15:0] cfg, input logic [2:0] op, input logic [3:0] rate,
		input logic [23:0] smp);
		level <= smp;
		apb(1'b1, ams_pkg::CONFIG_OFS, {16'h0, cfg});
		apb(1'b1, ams_pkg::MODE_OFS, {16'h0, op, 9'h0, rate});
		#1;
		{shortSeen, routeSeen, rdySeen, pdSeen} = {inputShort, fullScaleRoute, readyN, powerDown};
		cycles = 0;
		while (readyN !== 1'b0) begin
			@(posedge ref_clk);
			#1;
			cycles++;
		end
	endtask

	task automatic tReset();
		apb(1'b0, ams_pkg::MODE_OFS, 32'h0);
		check(rd, 32'h400a);
		apb(1'b0, ams_pkg::CONFIG_OFS, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 8'h30, 32'h0);
		check({rd[30:0], er}, 32'h1);
		check(32'(readyN), 32'h1);
	endtask

	task automatic tSingle();
		runOp(16'h6030, ams_pkg::OP_SINGLE, 4'h1, 24'h123456);
		check({30'h0, rdySeen, pdSeen}, 32'h2);
		check(cycles, 32'd4000);
		check(32'(powerDown), 32'h1);
		check(pins(), 32'h0);
		apb(1'b0, ams_pkg::STATUS_OFS, 32'h0);
		check(rd, 32'h12);
		check(32'(irq), 32'h0);
		apb(1'b1, ams_pkg::IRQ_MSK_OFS, 32'h7);
		apb(1'b0, ams_pkg::IRQ_ST_OFS, 32'h0);
		check(rd, 32'h1);
		check({30'h0, irq, readyN}, 32'h2);
		apb(1'b1, ams_pkg::IRQ_ST_OFS, 32'h7);
		apb(1'b0, ams_pkg::DATA_OFS, 32'h0);
		check(rd, 32'h123456);
		#1;
		check({30'h0, irq, readyN}, 32'h1);
	endtask

	task automatic tModes();
		apb(1'b1, ams_pkg::MODE_OFS, {16'h0, ams_pkg::OP_IDLE, 13'h1});
		#1;
		check({29'h0, filterReset, modulatorClkEn, powerDown}, 32'h6);
		check(pins(), 32'hf);
		apb(1'b1, ams_pkg::MODE_OFS, {16'h0, ams_pkg::OP_PDOWN, 13'h1});
		#1;
		check({29'h0, filterReset, modulatorClkEn, powerDown}, 32'h5);
		check(pins(), 32'h0);
		apb(1'b1, ams_pkg::MODE_OFS, {16'h0, ams_pkg::OP_CONT, 13'h1});
		#1;
		check({29'h0, filterReset, modulatorClkEn, powerDown}, 32'h6);
	endtask

	task automatic tZero();
		runOp(16'h0001, ams_pkg::OP_ZCAL, 4'h2, 24'h0abcde);
		check(cycles, 32'd8000);
		check({30'h0, shortSeen, rdySeen}, 32'h3);
		check({30'h0, filterReset, powerDown}, 32'h2);
		apb(1'b0, ams_pkg::MODE_OFS, 32'h0);
		check(32'(rd[15:13]), 32'(ams_pkg::OP_IDLE));
		apb(1'b0, ams_pkg::OFFSET_BASE + 8'h4, 32'h0);
		check(rd, 32'h0abcde);
		apb(1'b0, ams_pkg::IRQ_ST_OFS, 32'h0);
		check(rd, 32'h2);
		apb(1'b1, ams_pkg::IRQ_ST_OFS, 32'h7);
	endtask

	task automatic tFull();
		logic [15:0] cfg [4] = '{16'h0102, 16'h0000, 16'h0081, 16'h0701};
		logic [23:0] smp [4] = '{24'h111111, 24'h222222, 24'h333333, 24'h444444};
		logic [23:0] exp [4] = '{24'h111111, 24'h222222, FACT, FACT};
		logic [7:0]  adr [4] = '{8'h24, 8'h1c, 8'h20, 8'h20};
		logic [31:0] len [4] = '{32'd8000, 32'd4000, 32'd1, 32'd1};
		logic [31:0] flg [4] = '{32'h2, 32'h2, 32'h2, 32'h4};
		for (int i = 0; i < 4; i++) begin
			runOp(cfg[i], ams_pkg::OP_FCAL, 4'h1, smp[i]);
			check(cycles, len[i]);
			check({30'h0, routeSeen, rdySeen}, {30'h0, i < 2, 1'b1});
			check({30'h0, filterReset, powerDown}, 32'h2);
			apb(1'b0, adr[i], 32'h0);
			check(rd, {8'h0, exp[i]});
			apb(1'b0, ams_pkg::IRQ_ST_OFS, 32'h0);
			check(rd, flg[i]);
			apb(1'b1, ams_pkg::IRQ_ST_OFS, 32'h7);
		end
	endtask

	initial begin
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		tReset();
		tSingle();
		tModes();
		tZero();
		tFull();
		results();
	end
endmodule
